// File: rtl/vic_ctrl.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
module vic_ctrl (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    nmi_n,
    ext_req_n,
    int_req,
    watchdog_overflow_request,
    cpu_mask,
    standby,
    vec_ack,
    irq_req,
    irq_vec,
    irq_addr,
    irq_nmi
);
    input wire logic pclk;
    input wire logic presetn;
    input wire logic psel;
    input wire logic penable;
    input wire logic pwrite;
    input wire logic [15:0] paddr;
    input wire logic [31:0] pwdata;
    output logic [31:0] prdata;
    output logic pready;
    output logic pslverr;
    input wire logic nmi_n;
    input wire logic [7:0] ext_req_n;
    input wire logic [31:0] int_req;
    input wire logic watchdog_overflow_request;
    input wire logic cpu_mask;
    input wire logic standby;
    input wire logic vec_ack;
    output logic irq_req;
    output logic [5:0] irq_vec;
    output logic [6:0] irq_addr;
    output logic irq_nmi;

    // *************************************************************
    // Registers
    // *************************************************************
    logic [7:0] sysctl_reg;
    logic [7:0] sense_reg;
    logic [7:0] enable_reg;
    logic wd_route_reg;
    logic [7:0] ext_pend_reg;
    logic nmi_pend_reg;
    logic mask_s1_reg;
    logic mask_s2_reg;
    logic stby_s1_reg;
    logic stby_s2_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_req_reg;
    logic [5:0] irq_vec_reg;
    logic [6:0] irq_addr_reg;
    logic irq_nmi_reg;

    // *************************************************************
    // Bus decode
    // *************************************************************
    function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
        hit = (a == r);
    endfunction : hit

    wire setup_w = psel && !penable;
    wire sel_sys = hit(paddr, vic_pkg::VIC_SYSCTL_ADDR);
    wire sel_sense = hit(paddr, vic_pkg::VIC_SENSE_ADDR);
    wire sel_en = hit(paddr, vic_pkg::VIC_ENABLE_ADDR);
    wire sel_wd = hit(paddr, vic_pkg::VIC_WDCFG_ADDR);
    wire mapped = sel_sys || sel_sense || sel_en || sel_wd;
    // Write lands on the access edge, which is the one after setup.
    wire wr_now = psel && penable && pready_reg && pwrite && mapped;
    wire [7:0] wbyte = pwdata[7:0];
    wire [7:0] rd_byte = sel_sys ? sysctl_reg :
                         sel_sense ? sense_reg :
                         sel_en ? enable_reg :
                         sel_wd ? {7'h00, wd_route_reg} : 8'h00;

    // *************************************************************
    // Input detection
    // *************************************************************
    wire [7:0] ext_level;
    wire [7:0] ext_fall;
    wire nmi_fall;
    wire nmi_rise;

    genvar g;
    generate
        for (g = 0; g < vic_pkg::VIC_NEXT; g++) begin : g_line
            vic_line_detect u_det (
                .pclk(pclk),
                .presetn(presetn),
                .pin_n(ext_req_n[g]),
                .falling_mode(sense_reg[g]),
                .level_low(ext_level[g]),
                .fall_pulse(ext_fall[g]),
                .rise_pulse()
            );
        end
    endgenerate

    vic_line_detect u_nmi (
        .pclk(pclk),
        .presetn(presetn),
        .pin_n(nmi_n),
        .falling_mode(1'b1),
        .level_low(),
        .fall_pulse(nmi_fall),
        .rise_pulse(nmi_rise)
    );

    wire nmi_edge_sel = sysctl_reg[vic_pkg::VIC_NMI_EDGE_BIT];
    wire nmi_edge = nmi_edge_sel ? nmi_rise : nmi_fall;
    // Watchdog overflow may stand in for the nonmaskable pin.
    wire wd_to_nmi = wd_route_reg && watchdog_overflow_request;
    wire nmi_event = (nmi_edge || wd_to_nmi) && !stby_s2_reg;

    // *************************************************************
    // Arbitration
    // *************************************************************
    wire taken = irq_req_reg && vec_ack;
    wire [5:0] taken_vec = irq_vec_reg;
    wire [7:0] ext_taken;
    wire [7:0] ext_active;
    wire [7:0] pend_clr;

    for (g = 0; g < vic_pkg::VIC_NEXT; g++) begin : g_clr
        assign ext_taken[g] = taken &&
            (taken_vec == vic_pkg::VIC_VEC_EXT0 + 6'(g));
        // Pending edge is dropped when masked, disabled and set to level.
        assign pend_clr[g] = ext_taken[g] ||
            (mask_s2_reg && !sense_reg[g] && !enable_reg[g]);
        // A flag taken at this edge must not be offered a second time.
        assign ext_active[g] = sense_reg[g]
            ? (ext_pend_reg[g] && !ext_taken[g])
            : (ext_level[g] && enable_reg[g]);
    end

    // An edge is latched only while enabled; a held edge outlives a
    // later disable, so a handler can still run afterwards.
    wire [7:0] ext_set = ext_fall & sense_reg & enable_reg;
    wire [7:0] ext_pend_next = (ext_pend_reg & ~pend_clr) | ext_set;
    wire nmi_pend_next = (nmi_pend_reg &&
        !(taken && irq_nmi_reg)) || nmi_event;

    wire [31:0] int_gated = {int_req[31:0]};
    wire wd_maskable = !wd_route_reg && watchdog_overflow_request;
    wire maskable_ok = !mask_s2_reg;
    wire [vic_pkg::VIC_NINT-1:0] int_all = {wd_maskable, int_gated};
    wire [44:0] req_vec;
    assign req_vec[2:0] = 3'h0;
    // The flag clears at the ack edge, so it is dropped from that edge's
    // arbitration; otherwise the taken vector would be offered again.
    assign req_vec[3] = nmi_pend_reg && !(taken && irq_nmi_reg);
    assign req_vec[11:4] = ext_active & {8{maskable_ok}};
    assign req_vec[44:12] = int_all & {vic_pkg::VIC_NINT{maskable_ok}};

    wire win_found;
    wire [5:0] win_vec;
    vic_prio_enc u_prio (
        .req(req_vec),
        .found(win_found),
        .vec(win_vec)
    );

    // Presentation holds steady while waiting for the CPU, except a
    // newly pending nonmaskable request preempts a maskable offer.
    wire hold = irq_req_reg && !vec_ack && !(nmi_pend_reg && !irq_nmi_reg);

    // *************************************************************
    // Sequential logic
    // *************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysctl_reg <= vic_pkg::VIC_SYSCTL_RESET;
            sense_reg <= vic_pkg::VIC_SENSE_RESET;
            enable_reg <= vic_pkg::VIC_ENABLE_RESET;
            wd_route_reg <= 1'b0;
        end else if (wr_now) begin
            if (sel_sys) begin
                sysctl_reg <= (wbyte & vic_pkg::VIC_SYSCTL_WMASK) |
                    (sysctl_reg & ~vic_pkg::VIC_SYSCTL_WMASK);
            end
            if (sel_sense) begin
                sense_reg <= wbyte;
            end
            if (sel_en) begin
                enable_reg <= wbyte;
            end
            if (sel_wd) begin
                wd_route_reg <= wbyte[vic_pkg::VIC_WD_ROUTE_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_s1_reg <= 1'b1;
            mask_s2_reg <= 1'b1;
            stby_s1_reg <= 1'b0;
            stby_s2_reg <= 1'b0;
            ext_pend_reg <= 8'h00;
            nmi_pend_reg <= 1'b0;
        end else begin
            mask_s1_reg <= cpu_mask;
            mask_s2_reg <= mask_s1_reg;
            stby_s1_reg <= standby;
            stby_s2_reg <= stby_s1_reg;
            ext_pend_reg <= ext_pend_next;
            nmi_pend_reg <= nmi_pend_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup_w;
            pslverr_reg <= setup_w && !mapped;
            prdata_reg <= (setup_w && !pwrite) ? {24'h000000, rd_byte}
                                               : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req_reg <= 1'b0;
            irq_vec_reg <= 6'h00;
            irq_addr_reg <= 7'h00;
            irq_nmi_reg <= 1'b0;
        end else if (!hold) begin
            irq_req_reg <= win_found;
            irq_vec_reg <= win_vec;
            irq_addr_reg <= {win_vec, 1'b0};
            irq_nmi_reg <= win_found && (win_vec == vic_pkg::VIC_VEC_NMI);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq_req = irq_req_reg;
    assign irq_vec = irq_vec_reg;
    assign irq_addr = irq_addr_reg;
    assign irq_nmi = irq_nmi_reg;
endmodule : vic_ctrl

// File: rtl/vic_line_detect.sv
`timescale 1ns/1ns
module vic_line_detect (
    pclk,
    presetn,
    pin_n,
    falling_mode,
    level_low,
    fall_pulse,
    rise_pulse
);
    input wire logic pclk;
    input wire logic presetn;
    input wire logic pin_n;
    input wire logic falling_mode;
    output logic level_low;
    output logic fall_pulse;
    output logic rise_pulse;

    // Sync stage resets high so an idle-high pin makes no edge at release.
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            sync1_reg <= pin_n;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign level_low = !falling_mode && !sync2_reg;
    assign fall_pulse = prev_reg && !sync2_reg;
    assign rise_pulse = !prev_reg && sync2_reg;
endmodule : vic_line_detect

// File: rtl/vic_pkg.sv
// Behaviour
// - Nonmaskable request ignores mask, wins always
// - Mask bit one blocks all maskable requests
// - Each external line has own sense
// - Nonmaskable edge chosen by control bit two
// - Sense bit zero low level, one falling
// - Highest priority pending request presented first
// - Lower vector wins; entry at twice number
// - Vector three nonmaskable, four-eleven external lines
// - Reset and reserved vectors never presented
// - Thirty-three internal requests at twelve-forty-four
// - Every source gets a distinct vector
// - Watchdog overflow routed nonmaskable or own vector
// - Registers decoded at FFC4, FFC6, FFC7
// - Enable bit per line, zero blocks
// - Maskable accepted only enabled and unmasked
// - One request passed; CPU latches vector later
// - Nonmaskable accepted except reset or standby
package vic_pkg;
    // *************************************************************
    // Register map
    // *************************************************************
    localparam logic [15:0] VIC_SYSCTL_ADDR = 16'hFFC4;
    localparam logic [15:0] VIC_SENSE_ADDR = 16'hFFC6;
    localparam logic [15:0] VIC_ENABLE_ADDR = 16'hFFC7;
    // Own register: watchdog routing control bit, read back in bit zero.
    localparam logic [15:0] VIC_WDCFG_ADDR = 16'hFFC8;
    localparam logic [7:0] VIC_SYSCTL_RESET = 8'h09;
    localparam logic [7:0] VIC_SYSCTL_WMASK = 8'hF7;
    localparam logic [7:0] VIC_SENSE_RESET = 8'h00;
    localparam logic [7:0] VIC_ENABLE_RESET = 8'h00;
    localparam int VIC_NMI_EDGE_BIT = 2;
    localparam int VIC_WD_ROUTE_BIT = 0;
    // *************************************************************
    // Vectors
    // *************************************************************
    localparam int VIC_NVEC = 45;
    localparam int VIC_NINT = 33;
    localparam int VIC_NEXT = 8;
    localparam logic [5:0] VIC_VEC_NMI = 6'h03;
    localparam logic [5:0] VIC_VEC_EXT0 = 6'h04;
    localparam logic [5:0] VIC_VEC_INT0 = 6'h0C;
    localparam logic [5:0] VIC_VEC_WDOVF = 6'h2C;
    localparam int VIC_WD_INT_INDEX = 32;
endpackage : vic_pkg

// File: rtl/vic_prio_enc.sv
`timescale 1ns/1ns
module vic_prio_enc (
    req,
    found,
    vec
);
    input wire logic [44:0] req;
    output logic found;
    output logic [5:0] vec;

    // Scanning from the top down lets the lowest number win.
    always_comb begin
        found = 1'b0;
        vec = 6'h00;
        for (int i = 44; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                vec = 6'(i);
            end
        end
    end
endmodule : vic_prio_enc

// File: verif/test_vic_ctrl.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    error_cnt++; $display("[ERR] %0t got %h want %h", $time, a, b); \
    end end
module test_vic_ctrl;
    logic pclk, presetn, psel, penable, pwrite, nmi_n, wd, cpu_mask;
    logic standby, go;
    logic [15:0] paddr;
    logic [31:0] pwdata, int_req;
    logic [7:0] ext_req_n;
    wire logic [31:0] prdata;
    wire logic [5:0] irq_vec, got_vec;
    wire logic [6:0] irq_addr;
    wire logic pready, pslverr, irq_req, irq_nmi, vec_ack, taken;
    int error_cnt, checks_done;
    vic_ctrl vic_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nmi_n(nmi_n), .ext_req_n(ext_req_n),
        .int_req(int_req), .watchdog_overflow_request(wd),
        .cpu_mask(cpu_mask), .standby(standby), .vec_ack(vec_ack),
        .irq_req(irq_req), .irq_vec(irq_vec), .irq_addr(irq_addr),
        .irq_nmi(irq_nmi));
    vic_cpu_model vic_cpu_model_i (.pclk(pclk), .presetn(presetn),
        .go(go), .irq_req(irq_req), .irq_vec(irq_vec),
        .vec_ack(vec_ack), .got_vec(got_vec), .taken(taken));
    // ****************************************
    // Bus, CPU and check helpers
    // ****************************************
    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [7:0] d, input logic [7:0] x, input logic xe);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t bus answer timed out", $time);
            conclude();
        end
        if (!w) `CHK(prdata, {24'h0, x})
        `CHK(pslverr, xe)
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic take(input logic [5:0] v);
        int n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        while (taken !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (taken !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t vector not taken", $time);
            conclude();
        end
        `CHK(got_vec, v)
    endtask : take
    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge pclk);
            if (irq_req !== 1'b0) seen = 1'b1;
        end
        `CHK(seen, 1'b0)
    endtask : quiet
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        apb(1'b0, vic_pkg::VIC_SYSCTL_ADDR, 8'h00, 8'h09, 1'b0);
        apb(1'b0, vic_pkg::VIC_SENSE_ADDR, 8'h00, 8'h00, 1'b0);
        apb(1'b0, vic_pkg::VIC_ENABLE_ADDR, 8'h00, 8'h00, 1'b0);
        apb(1'b1, vic_pkg::VIC_SYSCTL_ADDR, 8'h00, 8'h00, 1'b0);
        apb(1'b0, vic_pkg::VIC_SYSCTL_ADDR, 8'h00, 8'h08, 1'b0);
        apb(1'b1, 16'hFFC5, 8'hFF, 8'h00, 1'b1);
        apb(1'b0, 16'hFFC5, 8'h00, 8'h00, 1'b1);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_nmi();
        nmi_n <= 1'b0;
        take(vic_pkg::VIC_VEC_NMI);
        apb(1'b1, vic_pkg::VIC_SYSCTL_ADDR, 8'h04, 8'h00, 1'b0);
        nmi_n <= 1'b1;
        take(vic_pkg::VIC_VEC_NMI);
        nmi_n <= 1'b0;
        quiet(12);
        $display("t_nmi done");
    endtask : t_nmi
    task automatic t_vec();
        // Requests gather while masked, so all are pending together.
        apb(1'b1, vic_pkg::VIC_SENSE_ADDR, 8'hFF, 8'h00, 1'b0);
        apb(1'b1, vic_pkg::VIC_ENABLE_ADDR, 8'hFF, 8'h00, 1'b0);
        ext_req_n <= 8'hF5;
        int_req <= 32'h1;
        repeat (4) @(posedge pclk);
        ext_req_n <= 8'hFF;
        cpu_mask <= 1'b0;
        take(6'h05);
        repeat (5) @(posedge pclk);
        take(6'h07);
        int_req <= 32'h0;
        take(6'h0C);
        int_req <= 32'h8000_0000;
        wd <= 1'b1;
        repeat (6) @(posedge pclk);
        int_req <= 32'h0;
        take(6'h2B);
        wd <= 1'b0;
        take(vic_pkg::VIC_VEC_WDOVF);
        apb(1'b1, vic_pkg::VIC_WDCFG_ADDR, 8'h01, 8'h00, 1'b0);
        apb(1'b0, vic_pkg::VIC_WDCFG_ADDR, 8'h00, 8'h01, 1'b0);
        wd <= 1'b1;
        repeat (6) @(posedge pclk);
        wd <= 1'b0;
        take(vic_pkg::VIC_VEC_NMI);
        apb(1'b1, vic_pkg::VIC_WDCFG_ADDR, 8'h00, 8'h00, 1'b0);
        quiet(10);
        $display("t_vec done");
    endtask : t_vec
    task automatic t_mask();
        cpu_mask <= 1'b1;
        apb(1'b1, vic_pkg::VIC_SENSE_ADDR, 8'hFB, 8'h00, 1'b0);
        ext_req_n <= 8'hFB;
        quiet(12);
        cpu_mask <= 1'b0;
        repeat (8) @(posedge pclk);
        ext_req_n <= 8'hFF;
        take(6'h06);
        apb(1'b1, vic_pkg::VIC_ENABLE_ADDR, 8'hFB, 8'h00, 1'b0);
        ext_req_n <= 8'hFB;
        quiet(12);
        ext_req_n <= 8'hFF;
        $display("t_mask done");
    endtask : t_mask
    task automatic t_stby();
        standby <= 1'b1;
        repeat (4) @(posedge pclk);
        nmi_n <= 1'b1;
        quiet(12);
        int_req <= 32'h1;
        @(posedge pclk);
        int_req <= 32'h0;
        take(vic_pkg::VIC_VEC_INT0);
        standby <= 1'b0;
        $display("t_stby done");
    endtask : t_stby
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, wd, standby, go} = 7'h00;
        {nmi_n, cpu_mask} = 2'h3;
        paddr = 16'h0000;
        pwdata = 32'h0;
        int_req = 32'h0;
        ext_req_n = 8'hFF;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_nmi();
        t_vec();
        t_mask();
        t_stby();
        conclude();
    end
endmodule : test_vic_ctrl

// File: verif/vic_cpu_model.sv
`timescale 1ns/1ns
module vic_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic irq_req,
    input wire logic [5:0] irq_vec,
    output logic vec_ack,
    output logic [5:0] got_vec,
    output logic taken
);
    // ****************************************
    // Takes one vector for each go pulse
    // ****************************************
    // Acking only once per go keeps a standing level source from being
    // taken twice before the bench can drop it.
    logic armed;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b0;
            vec_ack <= 1'b0;
            taken <= 1'b0;
            got_vec <= 6'h00;
        end else begin
            taken <= vec_ack && irq_req;
            if (vec_ack && irq_req) begin
                got_vec <= irq_vec;
            end
            vec_ack <= armed && irq_req && !vec_ack;
            if (go) begin
                armed <= 1'b1;
            end else if (vec_ack) begin
                armed <= 1'b0;
            end
        end
    end
endmodule : vic_cpu_model

// File: verif/vic_ctrl_asserts.sv
`timescale 1ns/1ns
module vic_ctrl_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpu_mask,
    input wire logic standby,
    input wire logic vec_ack,
    input wire logic irq_req,
    input wire logic [5:0] irq_vec,
    input wire logic [6:0] irq_addr,
    input wire logic irq_nmi
);
    // ****************************************
    // Port relations
    // ****************************************
    wire logic mapped;
    assign mapped = paddr == vic_pkg::VIC_SYSCTL_ADDR
        || paddr == vic_pkg::VIC_SENSE_ADDR
        || paddr == vic_pkg::VIC_ENABLE_ADDR
        || paddr == vic_pkg::VIC_WDCFG_ADDR;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_addr_twice:
        assert property (irq_req |-> irq_addr == {irq_vec, 1'b0})
        else $error("vector address mismatch");
    a_vec_range:
        assert property (irq_req |-> irq_vec >= vic_pkg::VIC_VEC_NMI
            && irq_vec <= vic_pkg::VIC_VEC_WDOVF)
        else $error("vector out of range");
    a_nmi_vector:
        assert property (irq_req && irq_nmi |-> irq_vec == 6'h03)
        else $error("nonmaskable vector wrong");
    a_mask_blocks:
        assert property (cpu_mask [*6] ##1 $rose(irq_req) |-> irq_nmi)
        else $error("maskable offer while masked");
    a_standby_nmi:
        assert property (standby [*6] ##1 $rose(irq_req) |-> !irq_nmi)
        else $error("nonmaskable offer in standby");
    a_offer_holds:
        assert property (irq_req && !vec_ack |=> irq_req
            && (irq_nmi || $stable(irq_vec)))
        else $error("offer dropped before ack");
    a_pready_access:
        assert property (pready |-> psel && penable
            && $past(psel && !penable))
        else $error("pready outside access");
    a_slverr_map:
        assert property (pready |-> pslverr == !mapped)
        else $error("decode error wrong");
    a_err_zero:
        assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : vic_ctrl_asserts
bind vic_ctrl vic_ctrl_asserts vic_ctrl_asserts_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_mask(cpu_mask), .standby(standby), .vec_ack(vec_ack),
    .irq_req(irq_req), .irq_vec(irq_vec), .irq_addr(irq_addr),
    .irq_nmi(irq_nmi));
